// ==== meh_error_handler.sv ====
// Memory unit error handler: parity error capture, parity reactions, fill error propagation.
// Assumes one clock, synchronous inputs, and an APB master for the error registers.
// What this block does
// - Unlocked xlate parity error captures address, status, lock
// - Tag and data parity flags may set together
// - Locked registers freeze; later errors dropped
// - Lock zero means register contents invalid
// - Writing one to lock clears it
// - Cache pair captures quadword address, PTE hard errors
// - Locked cache status disables cache accesses
// - Controller errors forwarded; only PTE hard errors logged locally
// - ECC error fill becomes no-op, no strobes
// - Hard error requested data returned, flagged hard
// - Hard error ends fill; miss latch invalidated
// - Hard error fill acts as block invalidate
// - Xlate parity: microtrap, flush, invalidate all, record
// - Cache tag parity read: force miss, interrupt, record
// - Cache data parity read or write: late enable, interrupt, record
// - Invalidate hitting tag parity still performed
// - PTE read hard error recorded; miss sequence ends
// - Instruction reference: tag latch, data or queue status
// - Execution reference non-probe: memory management trap
`timescale 1ns/1ps
`include "meh_params.svh"
module meh_error_handler (
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_i,
  // APB slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire meh_pkg::meh_word_t pwdata_i,
  output meh_pkg::meh_word_t prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // Translation buffer checks
  input wire logic xlate_tag_perr_i,
  input wire logic xlate_data_perr_i,
  input wire meh_pkg::meh_word_t xlate_vaddr_i,
  // Primary cache checks
  input wire logic l1_tag_perr_i,
  input wire logic l1_data_perr_i,
  input wire logic l1_ref_read_i,
  input wire logic l1_ref_write_i,
  input wire logic l1_ref_invalidate_cmd_i,
  input wire logic [28:0] l1_qw_paddr_i,
  // Fill return from second-level cache controller
  input wire meh_pkg::meh_cmd_t fill_cmd_i,
  input wire logic fill_req_qw_i,
  input wire logic fill_ecc_err_i,
  input wire logic fill_hard_err_i,
  input wire logic fill_last_i,
  input wire logic [63:0] fill_data_i,
  input wire logic fill_is_pte_i,
  input wire logic pte_for_ibox_i,
  input wire logic pte_ebox_probe_i,
  input wire logic pte_destination_address_cmd_i,
  input wire logic [28:0] fill_qw_paddr_i,
  // Reactions to the pipeline
  output logic xlate_parity_microtrap_o,
  output logic invalidate_all_xlate_o,
  output logic flush_refs_o,
  output logic force_miss_o,
  output logic cbox_late_en_o,
  output logic soft_err_irq_o,
  output logic l1_access_disable_o,
  output logic invalidate_cmd_allow_o,
  // Fill side results
  output logic [63:0] result_data_bus_o,
  output logic vcache_data_valid_o,
  output logic result_valid_o,
  output logic result_hard_err_o,
  output logic instr_cache_fill_o,
  output logic data_cache_fill_o,
  output logic invalidate_cmd_o,
  output logic miss_latch_clear_o,
  output logic xlate_miss_abort_o,
  output logic iref_err_tag_o,
  output logic [2:0] paddr_queue_status_o,
  output logic mm_trap_o
);
  import meh_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Error register state
  meh_sts_t tb_sts_q, tb_sts_d;
  meh_word_t tb_adr_q, tb_adr_d;
  meh_sts_t pc_sts_q, pc_sts_d;
  meh_word_t pc_adr_q, pc_adr_d;
  meh_word_t prdata_q, prdata_d;
  logic [63:0] md_q;
  logic md_vld_q, md_vic_q, md_herr_q;
  logic irq_q;
  logic rd_wait_q;

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode
  wire apb_acc = psel_i & penable_i;
  wire apb_wr = apb_acc & pwrite_i;
  wire sel_tbs = paddr_i == `MEH_OFF_TB_STS;
  wire sel_tba = paddr_i == `MEH_OFF_TB_ADR;
  wire sel_pcs = paddr_i == `MEH_OFF_PC_STS;
  wire sel_pca = paddr_i == `MEH_OFF_PC_ADR;
  wire mapped = sel_tbs | sel_tba | sel_pcs | sel_pca;
  // Writing one to lock re-arms capture
  wire tb_unlock = apb_wr & sel_tbs & pwdata_i[`MEH_BIT_LOCK];
  wire pc_unlock = apb_wr & sel_pcs & pwdata_i[`MEH_BIT_LOCK];
  // Reads take one wait state so the answer comes from a flop
  wire rd_start = apb_acc & ~pwrite_i & ~rd_wait_q;
  assign pready_o = ~(apb_acc & ~pwrite_i) | rd_wait_q;
  assign pslverr_o = apb_acc & ~mapped & pready_o;
  assign prdata_o = prdata_q;

  ////////////////////////////////////////////////////////////////////////////
  // Translation buffer parity
  wire tb_lock = tb_sts_q[`MEH_BIT_LOCK];
  wire tb_err = xlate_tag_perr_i | xlate_data_perr_i;
  // Capture only while unlocked; frozen otherwise
  wire tb_cap = tb_err & ~tb_lock;
  assign xlate_parity_microtrap_o = tb_err;
  assign invalidate_all_xlate_o = tb_err;
  assign flush_refs_o = tb_err;

  always_comb begin
    tb_sts_d = tb_sts_q;
    tb_adr_d = tb_adr_q;
    if (tb_cap) begin
      tb_sts_d = `MEH_STS_RESET;
      tb_sts_d[`MEH_BIT_LOCK] = 1'b1;
      tb_sts_d[`MEH_BIT_TAG_PARITY_FLAG] = xlate_tag_perr_i;
      tb_sts_d[`MEH_BIT_DATA_PARITY_FLAG] = xlate_data_perr_i;
      tb_adr_d = xlate_vaddr_i;
    end else if (tb_unlock) begin
      tb_sts_d[`MEH_BIT_LOCK] = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Primary cache parity and PTE hard errors
  wire pc_lock = pc_sts_q[`MEH_BIT_LOCK];
  wire pc_perr = (l1_tag_perr_i | l1_data_perr_i) & (l1_ref_read_i | l1_ref_write_i | l1_ref_invalidate_cmd_i);
  wire hard_fill = (fill_cmd_i == MEH_FILL_I || fill_cmd_i == MEH_FILL_D) & fill_hard_err_i & ~fill_ecc_err_i;
  wire pte_herr = hard_fill & fill_is_pte_i;
  wire pc_cap = (pc_perr | pte_herr) & ~pc_lock;
  wire [31:0] pc_addr_in = pc_perr ? {l1_qw_paddr_i, 3'h0} : {fill_qw_paddr_i, 3'h0};

  always_comb begin
    pc_sts_d = pc_sts_q;
    pc_adr_d = pc_adr_q;
    if (pc_cap) begin
      pc_sts_d = `MEH_STS_RESET;
      pc_sts_d[`MEH_BIT_LOCK] = 1'b1;
      pc_sts_d[`MEH_BIT_TAG_PARITY_FLAG] = pc_perr & l1_tag_perr_i;
      pc_sts_d[`MEH_BIT_DATA_PARITY_FLAG] = pc_perr & l1_data_perr_i;
      pc_sts_d[`MEH_BIT_PTE_HERR] = pte_herr;
      pc_sts_d[`MEH_BIT_WRREF] = pc_perr & l1_ref_write_i;
      pc_adr_d = pc_addr_in;
    end else if (pc_unlock) begin
      pc_sts_d[`MEH_BIT_LOCK] = 1'b0;
    end
  end

  assign l1_access_disable_o = pc_lock;
  assign force_miss_o = l1_tag_perr_i & l1_ref_read_i;
  assign cbox_late_en_o = l1_data_perr_i & (l1_ref_read_i | l1_ref_write_i);
  // Invalidate matches on all tag bits, so parity does not block it
  assign invalidate_cmd_allow_o = l1_ref_invalidate_cmd_i & ~pc_lock;
  assign soft_err_irq_o = irq_q;

  ////////////////////////////////////////////////////////////////////////////
  // Fill path: ECC no-op, hard error forwarding
  wire fill_cmd = fill_cmd_i == MEH_FILL_I || fill_cmd_i == MEH_FILL_D;
  // ECC error turns fill into a no-op; of controller errors only PTE hard errors are logged
  wire fill_ok = fill_cmd & ~fill_ecc_err_i & ~fill_hard_err_i;
  wire ret_data = fill_cmd & ~fill_ecc_err_i & fill_req_qw_i & ~fill_is_pte_i;
  assign instr_cache_fill_o = fill_ok & (fill_cmd_i == MEH_FILL_I) & ~pc_lock;
  assign data_cache_fill_o = fill_ok & (fill_cmd_i == MEH_FILL_D) & ~pc_lock;
  assign invalidate_cmd_o = (hard_fill | (fill_cmd_i == MEH_FILL_INVALIDATE_CMD)) & ~pc_lock;
  assign miss_latch_clear_o = hard_fill | (fill_cmd & ~fill_ecc_err_i & fill_last_i);
  assign xlate_miss_abort_o = pte_herr;
  assign iref_err_tag_o = pte_herr & pte_for_ibox_i;
  assign paddr_queue_status_o = {1'b0, pte_herr & pte_for_ibox_i & pte_destination_address_cmd_i, 1'b0};
  assign mm_trap_o = pte_herr & ~pte_for_ibox_i & ~pte_ebox_probe_i;
  assign result_data_bus_o = md_q;
  assign result_valid_o = md_vld_q;
  assign vcache_data_valid_o = md_vic_q;
  assign result_hard_err_o = md_herr_q;

  ////////////////////////////////////////////////////////////////////////////
  // Read data
  always_comb begin
    prdata_d = 32'h00000000;
    if (rd_start) begin
      if (sel_tbs) prdata_d = {27'h0000000, tb_sts_q};
      if (sel_tba) prdata_d = tb_adr_q;
      if (sel_pcs) prdata_d = {27'h0000000, pc_sts_q};
      if (sel_pca) prdata_d = pc_adr_q;
    end
  end
  // Loaded in the first access cycle, shown while pready is high
  wire meh_word_t rd_mux = prdata_d;

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      tb_sts_q <= `MEH_STS_RESET;
      tb_adr_q <= `MEH_ADR_RESET;
      pc_sts_q <= `MEH_STS_RESET;
      pc_adr_q <= `MEH_ADR_RESET;
      irq_q <= 1'b0;
    end else begin
      tb_sts_q <= tb_sts_d;
      tb_adr_q <= tb_adr_d;
      pc_sts_q <= pc_sts_d;
      pc_adr_q <= pc_adr_d;
      irq_q <= pc_perr & ~pc_lock;
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      md_q <= 64'h0000000000000000;
      md_vld_q <= 1'b0;
      md_vic_q <= 1'b0;
      md_herr_q <= 1'b0;
    end else begin
      md_q <= ret_data ? fill_data_i : md_q;
      md_vld_q <= ret_data;
      md_vic_q <= ret_data & (fill_cmd_i == MEH_FILL_I) & ~fill_hard_err_i;
      md_herr_q <= ret_data & fill_hard_err_i;
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      prdata_q <= 32'h00000000;
      rd_wait_q <= 1'b0;
    end else begin
      prdata_q <= rd_start ? rd_mux : prdata_q;
      rd_wait_q <= rd_start;
    end
  end
endmodule

// ==== meh_error_handler_chk.sv ====
// Checker: port relations of the error handler.
// Assumes it is bound into meh_error_handler.
`timescale 1ns/1ps
module meh_chk import meh_pkg::*; (
  input wire logic clock_i, rst_i, xlate_tag_perr_i, xlate_data_perr_i, xlate_parity_microtrap_o,
  input wire logic invalidate_all_xlate_o, l1_tag_perr_i, l1_data_perr_i, l1_ref_read_i, l1_ref_invalidate_cmd_i,
  input wire logic force_miss_o, cbox_late_en_o, invalidate_cmd_allow_o, soft_err_irq_o, l1_access_disable_o,
  input wire meh_cmd_t fill_cmd_i,
  input wire logic fill_ecc_err_i, fill_hard_err_i, fill_is_pte_i, pte_for_ibox_i, pte_ebox_probe_i,
  input wire logic flush_refs_o, iref_err_tag_o, pte_destination_address_cmd_i,
  input wire logic [2:0] paddr_queue_status_o,
  input wire logic instr_cache_fill_o, data_cache_fill_o, invalidate_cmd_o, miss_latch_clear_o,
  input wire logic xlate_miss_abort_o, mm_trap_o, result_valid_o, vcache_data_valid_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (rst_i);
  wire logic hard_w = fill_hard_err_i && !fill_ecc_err_i && (fill_cmd_i == MEH_FILL_I || fill_cmd_i == MEH_FILL_D);
  ////////////////////////////////////////////////////////////
  a_tb_trap_now: assert property ((xlate_tag_perr_i || xlate_data_perr_i) |->
    xlate_parity_microtrap_o && invalidate_all_xlate_o) else $error("no trap on xlate parity");
  a_miss_forced: assert property (l1_tag_perr_i && l1_ref_read_i |-> force_miss_o)
    else $error("no forced miss");
  a_late_enable: assert property (l1_data_perr_i && l1_ref_read_i |-> cbox_late_en_o)
    else $error("no late enable");
  a_irq_one_cycle: assert property ($rose(soft_err_irq_o) |=> !soft_err_irq_o)
    else $error("irq longer than one cycle");
  a_invalidate_cmd_kept: assert property (l1_ref_invalidate_cmd_i && !l1_access_disable_o |-> invalidate_cmd_allow_o)
    else $error("invalidate_cmd blocked");
  a_tb_flush: assert property ((xlate_tag_perr_i || xlate_data_perr_i) |-> flush_refs_o)
    else $error("no flush on xlate parity");
  a_iref_tag: assert property (hard_w && fill_is_pte_i && pte_for_ibox_i |->
    iref_err_tag_o && !mm_trap_o && (paddr_queue_status_o[1] == pte_destination_address_cmd_i)) else $error("iref not tagged");
  a_ecc_noop: assert property (fill_ecc_err_i |-> !instr_cache_fill_o && !data_cache_fill_o
    ##1 !result_valid_o && !vcache_data_valid_o) else $error("ecc fill not dropped");
  a_hard_invalidate_cmd: assert property (hard_w && !l1_access_disable_o |->
    invalidate_cmd_o && miss_latch_clear_o && !data_cache_fill_o)
    else $error("hard fill not invalidated");
  a_pte_abort: assert property (hard_w && fill_is_pte_i |-> xlate_miss_abort_o) else $error("miss not ended");
  a_mm_trap: assert property (hard_w && fill_is_pte_i && !pte_for_ibox_i && !pte_ebox_probe_i |-> mm_trap_o)
    else $error("no mm trap");
  a_locked_nofill: assert property (l1_access_disable_o |-> !instr_cache_fill_o && !data_cache_fill_o)
    else $error("fill while locked");
  c_hard: cover property (hard_w);
  c_irq: cover property (soft_err_irq_o);
  c_lock: cover property ($rose(l1_access_disable_o));
endmodule
bind meh_error_handler meh_chk meh_chk_i (.*);

// ==== meh_l2_model.sv ====
// Second-level cache controller model returning fill beats.
// Assumes the bench calls fill() between clock edges.
`timescale 1ns/1ps
module meh_l2_model import meh_pkg::*; (
  input wire logic clock_i,
  output meh_cmd_t cmd_o,
  output logic rq_o, ecc_o, hard_o, last_o,
  output logic [63:0] data_o
);
  logic [63:0] pat_q = 64'h5A5A5A5A5A5A5A5A, dat_q = 64'h0;
  initial {cmd_o, rq_o, ecc_o, hard_o, last_o} = '0;
  // Idle data bus keeps changing so a stale beat never looks valid
  always @(posedge clock_i) pat_q <= ~pat_q;
  assign data_o = (cmd_o == MEH_FILL_NONE) ? pat_q : dat_q;
  task automatic beat(input meh_cmd_t c, input logic e, h, input logic [63:0] d);
    @(posedge clock_i);
    cmd_o <= c; rq_o <= (c != MEH_FILL_NONE); ecc_o <= e; hard_o <= h; last_o <= (c != MEH_FILL_NONE) && !e;
    dat_q <= d;
  endtask
  task automatic fill(input meh_cmd_t c, input int kind, input logic [63:0] d);
    if (kind == 1) begin
      beat(c, 1'b1, 1'b0, d);
      beat(MEH_FILL_NONE, 1'b0, 1'b0, d);
    end
    beat(c, 1'b0, kind == 2, d);
    beat(MEH_FILL_NONE, 1'b0, 1'b0, d);
  endtask
endmodule

// ==== meh_params.svh ====
// Constants for the memory unit error handler: register offsets, field positions, reset values.
// Assumes inclusion by bare name from the package and the design file.
`ifndef MEH_PARAMS_SVH
`define MEH_PARAMS_SVH
`define MEH_OFF_TB_STS 12'h000
`define MEH_OFF_TB_ADR 12'h004
`define MEH_OFF_PC_STS 12'h008
`define MEH_OFF_PC_ADR 12'h00C
`define MEH_BIT_LOCK 0
`define MEH_BIT_TAG_PARITY_FLAG 1
`define MEH_BIT_DATA_PARITY_FLAG 2
`define MEH_BIT_PTE_HERR 3
`define MEH_BIT_WRREF 4
`define MEH_STS_RESET 5'h00
`define MEH_ADR_RESET 32'h00000000
`endif

// ==== meh_pkg.sv ====
// Types shared by the memory unit error handler.
// Assumes the params header is on the include path.
`include "meh_params.svh"
package meh_pkg;
  typedef logic [4:0] meh_sts_t;
  typedef logic [31:0] meh_word_t;
  typedef logic [1:0] meh_fill_t;
  typedef enum logic [1:0] {
    MEH_FILL_NONE = 2'h0,
    MEH_FILL_I = 2'h1,
    MEH_FILL_D = 2'h2,
    MEH_FILL_INVALIDATE_CMD = 2'h3
  } meh_cmd_t;
endpackage

// ==== tb_top.sv ====
// Bench: APB register access plus error and fill stimulus.
// Assumes the checker is bound and the model drives fills.
`timescale 1ns/1ps
`include "meh_params.svh"
module tb_top;
  import meh_pkg::*;
  logic clock_i = 0, rst_i = 1, psel_i = 0, penable_i = 0, pwrite_i = 0, slv;
  logic [11:0] paddr_i = 0;
  meh_word_t pwdata_i = 0, xlate_vaddr_i = 0, prdata_o;
  logic xlate_tag_perr_i = 0, xlate_data_perr_i = 0, l1_tag_perr_i = 0, l1_data_perr_i = 0;
  logic l1_ref_read_i = 0, l1_ref_write_i = 0, l1_ref_invalidate_cmd_i = 0, fill_is_pte_i = 0;
  logic pte_for_ibox_i = 0, pte_ebox_probe_i = 0, pte_destination_address_cmd_i = 0;
  logic [28:0] l1_qw_paddr_i = 0, fill_qw_paddr_i = 0;
  meh_cmd_t fill_cmd_i;
  logic fill_req_qw_i, fill_ecc_err_i, fill_hard_err_i, fill_last_i, pready_o, pslverr_o, soft_err_irq_o;
  logic l1_access_disable_o, result_valid_o, result_hard_err_o;
  logic [63:0] fill_data_i, result_data_bus_o;
  int n_mismatch = 0, checked = 0;
  meh_word_t rdat;
  meh_l2_model l2_i (.clock_i(clock_i), .cmd_o(fill_cmd_i), .rq_o(fill_req_qw_i), .ecc_o(fill_ecc_err_i),
    .hard_o(fill_hard_err_i), .last_o(fill_last_i), .data_o(fill_data_i));
  meh_error_handler meh_error_handler_i (.*, .xlate_parity_microtrap_o(), .invalidate_all_xlate_o(),
    .flush_refs_o(), .force_miss_o(), .cbox_late_en_o(), .invalidate_cmd_allow_o(), .vcache_data_valid_o(),
    .instr_cache_fill_o(), .data_cache_fill_o(), .invalidate_cmd_o(), .miss_latch_clear_o(),
    .xlate_miss_abort_o(), .iref_err_tag_o(), .paddr_queue_status_o(), .mm_trap_o());
  initial forever #50 clock_i = ~clock_i;
  ////////////////////////////////////////////////////////////
  task automatic stop_test();
    $display("checked %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic [63:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input meh_word_t d);
    int n;
    @(posedge clock_i);
    psel_i <= 1; pwrite_i <= w; paddr_i <= a; pwdata_i <= d;
    @(posedge clock_i);
    penable_i <= 1;
    n = 0;
    do begin @(posedge clock_i); n++; end while (pready_o !== 1'b1 && n < 50);
    if (n >= 50) begin n_mismatch++; stop_test(); end
    slv = pslverr_o;
    rdat = prdata_o;
    psel_i <= 0; penable_i <= 0;
  endtask
  task automatic rd(input logic [11:0] a, input meh_word_t e, input meh_word_t m = 32'hFFFFFFFF);
    apb(1'b0, a, 32'h0);
    chk({32'h0, rdat & m}, {32'h0, e});
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    repeat (2) @(posedge clock_i);
    rst_i <= 0;
    rd(`MEH_OFF_TB_STS, 32'h0);
    @(posedge clock_i); xlate_tag_perr_i <= 1; xlate_data_perr_i <= 1; xlate_vaddr_i <= 32'h8000A5C4;
    @(posedge clock_i); xlate_data_perr_i <= 0; xlate_vaddr_i <= 32'h00000040;
    @(posedge clock_i); xlate_tag_perr_i <= 0;
    rd(`MEH_OFF_TB_STS, 32'h7);
    rd(`MEH_OFF_TB_ADR, 32'h8000A5C4);
    apb(1'b1, `MEH_OFF_TB_STS, 32'h1);
    rd(`MEH_OFF_TB_STS, 32'h0, 32'h1);
    @(posedge clock_i); l1_tag_perr_i <= 1; l1_data_perr_i <= 1; l1_ref_read_i <= 1; l1_qw_paddr_i <= 29'h00ABCDE1;
    @(posedge clock_i); l1_tag_perr_i <= 0; l1_data_perr_i <= 0; l1_ref_read_i <= 0;
    #1 chk({62'h0, soft_err_irq_o, l1_access_disable_o}, 64'h3);
    rd(`MEH_OFF_PC_STS, 32'h7);
    rd(`MEH_OFF_PC_ADR, 32'h055E6F08);
    apb(1'b1, `MEH_OFF_PC_STS, 32'h1);
    l2_i.fill(MEH_FILL_I, 1, 64'h0123456789ABCDEF);
    #1 chk(result_data_bus_o, 64'h0123456789ABCDEF);
    l2_i.fill(MEH_FILL_D, 2, 64'hFEDCBA9876543210);
    #1 chk({result_hard_err_o, result_valid_o, result_data_bus_o[61:0]}, {2'h3, 62'h3EDCBA9876543210});
    rd(`MEH_OFF_PC_STS, 32'h0, 32'h1);
    fill_is_pte_i <= 1;
    l2_i.fill(MEH_FILL_D, 2, 64'h0);
    fill_is_pte_i <= 0;
    rd(`MEH_OFF_PC_STS, 32'h9, 32'h9);
    pte_for_ibox_i <= 1; pte_destination_address_cmd_i <= 1; fill_is_pte_i <= 1;
    l2_i.fill(MEH_FILL_I, 2, 64'h0);
    fill_is_pte_i <= 0; pte_for_ibox_i <= 0; pte_destination_address_cmd_i <= 0;
    rd(`MEH_OFF_PC_STS, 32'h9, 32'h1F);
    apb(1'b1, `MEH_OFF_PC_STS, 32'h1);
    @(posedge clock_i); l1_tag_perr_i <= 1; l1_ref_invalidate_cmd_i <= 1;
    @(posedge clock_i); l1_tag_perr_i <= 0; l1_ref_invalidate_cmd_i <= 0;
    #1 chk({63'h0, soft_err_irq_o}, 64'h1);
    rd(`MEH_OFF_PC_STS, 32'h3, 32'h1F);
    apb(1'b1, `MEH_OFF_PC_STS, 32'h1);
    @(posedge clock_i); l1_data_perr_i <= 1; l1_ref_write_i <= 1; l1_qw_paddr_i <= 29'h00000010;
    @(posedge clock_i); l1_data_perr_i <= 0; l1_ref_write_i <= 0;
    rd(`MEH_OFF_PC_STS, 32'h15, 32'h1F);
    apb(1'b0, 12'h010, 32'h0);
    chk({63'h0, slv}, 64'h1);
    stop_test();
  end
  initial begin
    #1000000;
    n_mismatch++;
    stop_test();
  end
endmodule
